// File: hw/phyev_core.sv
// phyev_core: event status, interrupt enable and reduced-interface control registers of the PHY
// Contract
// R01 - bit 9 picks full interface when 1, reduced when 0; reset from strap.
// R02 - far-end-fault used only when its enable is set and negotiation is off.
// R03 - control bit 2 enlarges the reduced-interface elasticity buffer; resets to zero.
// R04 - control bit 1 sends speed, link, duplex out of band while idle.
// R05 - status bit 10 shows fibre mode, which disables negotiation and scrambling.
// R06 - status bits 9 and 8 show speed and duplex, valid with link.
// R07 - status bit 7 shows pause after negotiation when both ends advertise it.
// R08 - status bit 6 latches negotiation done, gated by enable bit 6.
// R09 - status bit 5 latches remote fault, gated by enable bit 5.
// R10 - status bit 4 latches link fail, gated by enable bit 4.
// R11 - status bit 3 latches code word received, gated by enable bit 3.
// R12 - status bit 2 latches parallel detect fault, gated by enable bit 2.
// R13 - status bit 1 latches page received, gated by enable bit 1.
// R14 - status bit 0 latches at 64k errored packets; status read clears counter.
// R15 - enable bit 8 sets pin direction: 1 power-down input, 0 interrupt output.
// R16 - enable bit 7 is master enable, resetting to 0, blocking all interrupts.
// R17 - seven individual enables, resetting to 0, let their flag reach the interrupt.
// R18 - latched flags hold until their register is read, and clear on reset.
// R19 - interrupt driven when master set, pin is output, an enabled flag pending.
// R20 - reserved bits read their defaults; writes to read-only bits are ignored.
module phyev_core
    import phyev_pkg::*;
#(
    parameter int ERR_LIMIT = ERR_PKT_LIMIT,
    parameter logic [4:0] PHY_ADDR = PHY_ADDR_DEFAULT
) (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // strap sampled while reset is held
    input wire logic mii_strap,
    // management pins
    input wire logic mdc,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe,
    // link state and events from the datapath
    input wire phyev_link_t link,
    input wire phyev_evt_t evt,
    input wire logic tx_en,
    input wire logic crs_dv,
    // shared power-down or interrupt pin
    input wire logic powerdown_or_irq_pin_i,
    output logic powerdown_or_irq_pin_o,
    output logic powerdown_or_irq_pin_oe,
    output logic powerdown_req,
    // configuration towards the datapath
    output logic mii_select,
    output logic elastic_extend,
    output logic oob_signal_active,
    output logic far_end_fault_active,
    output logic autoneg_allowed,
    output logic scramble_allowed
);

    localparam int CW = $clog2(ERR_LIMIT) + 1;
    localparam logic [CW-1:0] LIMIT_M1 = CW'(ERR_LIMIT - 1);
    localparam logic [CW-1:0] LIMIT = CW'(ERR_LIMIT);

    typedef struct packed {
        logic [15:0] tc;
        logic [15:0] en;
        logic [EVT_W-1:0] flags;
        logic [CW-1:0] err_cnt;
        logic [15:0] rdata;
        logic pin_o;
        logic pin_oe;
        logic pd_req;
        logic mii_sel;
        logic elastic;
        logic oob_act;
        logic fef_act;
        logic an_ok;
        logic scr_ok;
    } phyev_core_state_t;

    phyev_core_state_t q, d;
    phyev_mgmt_t req;
    logic [15:0] status_word;
    logic status_clr;
    logic cnt_hit;
    logic an_effective;
    logic pending;

    // ------------------------------------------------------------
    // management frame slave
    // ------------------------------------------------------------
    phyev_mdio #(
        .PHY_ADDR(PHY_ADDR)
    ) u_mdio (
        .mclk(mclk),
        .srst(srst),
        .mdc(mdc),
        .mdio_i(mdio_i),
        .mdio_o(mdio_o),
        .mdio_oe(mdio_oe),
        .req(req),
        .rdata(q.rdata)
    );

    // ------------------------------------------------------------
    // read mux helper
    // ------------------------------------------------------------
    function automatic logic [15:0] reg_read(input logic [4:0] a, input logic [15:0] tc,
                                             input logic [15:0] en, input logic [15:0] st);
        logic [15:0] v;
        v = 16'h0000;
        unique case (a)
            REG_TEST_CTRL: v = tc;
            REG_STATUS: v = st;
            REG_IRQ_EN: v = en;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        // fibre mode overrides any negotiation request
        an_effective = link.an_enable & ~link.fibre; // [R05]
        status_word = 16'h0000; // [R20]
        status_word[ST_FIBRE] = link.fibre; // [R05]
        status_word[ST_SPEED] = link.speed100; // [R06]
        status_word[ST_DUPLEX] = link.full_duplex; // [R06]
        status_word[ST_PAUSE] = link.an_complete & link.local_sym_pause & link.partner_sym_pause; // [R07]
        status_word[EVT_W-1:0] = q.flags;

        status_clr = req.rd && req.addr == REG_STATUS; // [R18]
        cnt_hit = evt.rx_err_pkt && q.err_cnt == LIMIT_M1 && !status_clr; // [R14]

        d = q;
        if (req.rd) begin
            // capture before the clear so the read returns what was pending
            d.rdata = reg_read(req.addr, q.tc, q.en, status_word);
        end

        // on bits 6..1 set wins over the read clear so no event is lost; a bit 0 hit in the read cycle is dropped
        d.flags[EVT_W-1:1] = (q.flags[EVT_W-1:1] & {(EVT_W-1){~status_clr}})
                             | {evt.an_done, evt.remote_fault, evt.link_fail,
                                evt.code_word, evt.pd_fault, evt.page_rcvd}; // [R08] [R09] [R10] [R11] [R12] [R13] [R18]
        d.flags[EV_RX_FULL] = (q.flags[EV_RX_FULL] & ~status_clr) | cnt_hit; // [R14] [R18]

        // counter saturates at the limit until a status read clears it
        if (status_clr) begin
            d.err_cnt = evt.rx_err_pkt ? CW'(1) : '0; // [R14]
        end else if (evt.rx_err_pkt && q.err_cnt != LIMIT) begin
            d.err_cnt = q.err_cnt + CW'(1); // [R14]
        end

        if (req.wr) begin
            unique case (req.addr)
                REG_TEST_CTRL: d.tc = (q.tc & ~TC_RW_MASK) | (req.wdata & TC_RW_MASK); // [R20]
                REG_IRQ_EN: d.en = (q.en & ~EN_RW_MASK) | (req.wdata & EN_RW_MASK); // [R20]
                default: d.tc = q.tc;
            endcase
        end

        // outputs follow the next register values so they carry no extra lag
        pending = d.en[EN_MASTER] & |(d.flags & d.en[EVT_W-1:0]); // [R16] [R17]
        d.pin_oe = ~d.en[EN_PIN_DIR]; // [R15]
        d.pin_o = ~(pending & ~d.en[EN_PIN_DIR]); // [R19]
        d.pd_req = d.en[EN_PIN_DIR] & powerdown_or_irq_pin_i; // [R15]
        d.mii_sel = d.tc[TC_MII_SEL]; // [R01]
        // the larger buffer only exists on the reduced interface
        d.elastic = d.tc[TC_ELASTIC] & ~d.tc[TC_MII_SEL]; // [R03]
        d.oob_act = d.tc[TC_OOB] & ~d.tc[TC_MII_SEL] & ~tx_en & ~crs_dv; // [R04]
        d.fef_act = d.tc[TC_FEF] & ~an_effective; // [R02]
        d.an_ok = an_effective; // [R05]
        d.scr_ok = ~link.fibre; // [R05]

        if (srst) begin
            d = '0;
            d.tc = TC_RESET; // [R03]
            // strap is sampled for as long as reset is held
            d.tc[TC_MII_SEL] = mii_strap; // [R01]
            d.mii_sel = mii_strap; // [R01]
            d.en = EN_RESET; // [R15] [R16] [R17]
            d.pin_o = 1'b1;
            d.scr_ok = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        q <= d;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign powerdown_or_irq_pin_o = q.pin_o;
    assign powerdown_or_irq_pin_oe = q.pin_oe;
    assign powerdown_req = q.pd_req;
    assign mii_select = q.mii_sel;
    assign elastic_extend = q.elastic;
    assign oob_signal_active = q.oob_act;
    assign far_end_fault_active = q.fef_act;
    assign autoneg_allowed = q.an_ok;
    assign scramble_allowed = q.scr_ok;

endmodule // phyev_core

// File: pkg/phyev_pkg.sv
// phyev_pkg: shared constants and carriers for the PHY event, interrupt and reduced-interface config block
package phyev_pkg;

    // ------------------------------------------------------------
    // register addresses on the serial management interface
    // ------------------------------------------------------------
    localparam logic [4:0] REG_TEST_CTRL = 5'h10;
    localparam logic [4:0] REG_STATUS = 5'h11;
    localparam logic [4:0] REG_IRQ_EN = 5'h12;

    // ------------------------------------------------------------
    // reduced_interface_test_control fields
    // ------------------------------------------------------------
    localparam int TC_MII_SEL = 9;
    localparam int TC_FEF = 5;
    localparam int TC_ELASTIC = 2;
    localparam int TC_OOB = 1;
    localparam logic [15:0] TC_RW_MASK = 16'h27E7;
    localparam logic [15:0] TC_RESET = 16'h1000;

    // ------------------------------------------------------------
    // receiver_config_and_event_status fields
    // ------------------------------------------------------------
    localparam int ST_FIBRE = 10;
    localparam int ST_SPEED = 9;
    localparam int ST_DUPLEX = 8;
    localparam int ST_PAUSE = 7;
    localparam int EVT_W = 7;
    localparam int EV_RX_FULL = 0;

    // ------------------------------------------------------------
    // receiver_event_interrupt_enable fields
    // ------------------------------------------------------------
    localparam int EN_PIN_DIR = 8;
    localparam int EN_MASTER = 7;
    localparam logic [15:0] EN_RW_MASK = 16'h01FF;
    localparam logic [15:0] EN_RESET = 16'h0100;

    // ------------------------------------------------------------
    // counts and management frame layout
    // ------------------------------------------------------------
    localparam int ERR_PKT_LIMIT = 65536;
    localparam logic [4:0] PHY_ADDR_DEFAULT = 5'h01;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [4:0] HDR_LAST = 5'h0C;
    localparam logic [4:0] DATA_LAST = 5'h0F;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic fibre;
        logic speed100;
        logic full_duplex;
        logic an_enable;
        logic an_complete;
        logic local_sym_pause;
        logic partner_sym_pause;
    } phyev_link_t;

    // one-cycle event pulses, laid out as status bits 6..0
    typedef struct packed {
        logic an_done;
        logic remote_fault;
        logic link_fail;
        logic code_word;
        logic pd_fault;
        logic page_rcvd;
        logic rx_err_pkt;
    } phyev_evt_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] addr;
        logic [15:0] wdata;
    } phyev_mgmt_t;

endpackage

// File: hw/phyev_mdio.sv
// phyev_mdio: serial management frame slave turning read and write frames into register strobes
module phyev_mdio
    import phyev_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR = PHY_ADDR_DEFAULT
) (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // management pins
    input wire logic mdc,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe,
    // register side
    output phyev_mgmt_t req,
    input wire logic [15:0] rdata
);

    typedef enum logic [1:0] {S_IDLE, S_HDR, S_TA, S_DATA} phyev_mstate_t;

    typedef struct packed {
        phyev_mstate_t st;
        logic [4:0] cnt;
        logic [15:0] sh;
        logic is_read;
        logic mdc_prev;
        logic mdio_o;
        logic mdio_oe;
        phyev_mgmt_t req;
    } phyev_mdio_state_t;

    phyev_mdio_state_t q, d;
    logic rise;

    // mdc is a plain input, so each level must last one mclk for the edge to be seen
    assign rise = mdc & ~q.mdc_prev;

    always_comb begin
        d = q;
        d.mdc_prev = mdc;
        d.req.rd = 1'b0;
        d.req.wr = 1'b0;
        if (rise) begin
            unique case (q.st)
                S_IDLE: begin
                    d.mdio_oe = 1'b0;
                    // a zero after the run of ones is the first start bit
                    if (!mdio_i) begin
                        d.st = S_HDR;
                        d.cnt = 5'h00;
                        d.sh = 16'h0000;
                    end
                end
                S_HDR: begin
                    d.sh = {q.sh[14:0], mdio_i};
                    d.cnt = q.cnt + 5'h01;
                    if (q.cnt == HDR_LAST) begin
                        d.cnt = 5'h00;
                        d.st = S_IDLE;
                        if (d.sh[12] && d.sh[9:5] == PHY_ADDR &&
                            (d.sh[11:10] == OP_READ || d.sh[11:10] == OP_WRITE)) begin
                            d.st = S_TA;
                            d.req.addr = d.sh[4:0];
                            d.is_read = (d.sh[11:10] == OP_READ);
                            d.req.rd = (d.sh[11:10] == OP_READ);
                        end
                    end
                end
                S_TA: begin
                    d.cnt = q.cnt + 5'h01;
                    if (q.cnt == 5'h00) begin
                        // second turnaround bit is driven low on reads
                        d.mdio_oe = q.is_read;
                        d.mdio_o = 1'b0;
                    end else begin
                        d.st = S_DATA;
                        d.cnt = 5'h00;
                        d.sh = rdata;
                        d.mdio_o = rdata[15];
                    end
                end
                S_DATA: begin
                    d.cnt = q.cnt + 5'h01;
                    d.sh = {q.sh[14:0], mdio_i};
                    d.mdio_o = q.sh[14];
                    if (q.cnt == DATA_LAST) begin
                        d.st = S_IDLE;
                        d.mdio_oe = 1'b0;
                        d.req.wr = ~q.is_read;
                        d.req.wdata = {q.sh[14:0], mdio_i};
                    end
                end
            endcase
        end
        if (srst) begin
            d = '0;
            d.st = S_IDLE;
            // track mdc through reset so a high level at release is no false edge
            d.mdc_prev = mdc;
        end
    end

    always_ff @(posedge mclk) begin
        q <= d;
    end

    assign mdio_o = q.mdio_o;
    assign mdio_oe = q.mdio_oe;
    assign req = q.req;

endmodule // phyev_mdio

// File: bench/phyev_core_sva.sv
// phyev_core_sva: port-level checks for phyev_core
module phyev_core_sva
    import phyev_pkg::*;
#(
    parameter int ERR_LIMIT = ERR_PKT_LIMIT,
    parameter logic [4:0] PHY_ADDR = PHY_ADDR_DEFAULT
) (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // inputs of the core
    input wire logic mii_strap,
    input wire logic mdc,
    input wire logic mdio_i,
    input wire phyev_link_t link,
    input wire phyev_evt_t evt,
    input wire logic tx_en,
    input wire logic crs_dv,
    input wire logic powerdown_or_irq_pin_i,
    // outputs of the core
    input wire logic mdio_o,
    input wire logic mdio_oe,
    input wire logic powerdown_or_irq_pin_o,
    input wire logic powerdown_or_irq_pin_oe,
    input wire logic powerdown_req,
    input wire logic mii_select,
    input wire logic elastic_extend,
    input wire logic oob_signal_active,
    input wire logic far_end_fault_active,
    input wire logic autoneg_allowed,
    input wire logic scramble_allowed
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    // ------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------
    sequence s_rel;
        $fell(srst);
    endsequence
    sequence s_turn;
        $rose(mdio_oe) ##0 !mdio_o;
    endsequence

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_strap;
        s_rel |-> mii_select == $past(mii_strap);
    endproperty
    property p_rst_pin;
        s_rel |-> powerdown_or_irq_pin_o && !powerdown_or_irq_pin_oe;
    endproperty
    // past of srst keeps the first edge after release, still a reset value, out
    property p_an;
        !$past(srst) |-> autoneg_allowed == $past(link.an_enable && !link.fibre);
    endproperty
    property p_scr;
        !$past(srst) |-> scramble_allowed == !$past(link.fibre);
    endproperty
    property p_oob;
        oob_signal_active |-> !mii_select && !$past(tx_en) && !$past(crs_dv);
    endproperty
    property p_ext;
        elastic_extend |-> !mii_select;
    endproperty
    property p_fef;
        far_end_fault_active |-> !$past(link.an_enable && !link.fibre);
    endproperty
    property p_irq;
        !powerdown_or_irq_pin_o |-> powerdown_or_irq_pin_oe;
    endproperty
    property p_pd;
        powerdown_req |-> !powerdown_or_irq_pin_oe && $past(powerdown_or_irq_pin_i);
    endproperty
    property p_turn;
        s_turn |-> mdio_oe [*8];
    endproperty

    a_strap: assert property (p_strap) else $error("select bit missed the strap");
    a_rst_pin: assert property (p_rst_pin) else $error("pin not idle input after reset");
    a_an: assert property (p_an) else $error("negotiation permit wrong");
    a_scr: assert property (p_scr) else $error("scrambler permit wrong");
    a_oob: assert property (p_oob) else $error("out of band while busy or full");
    a_ext: assert property (p_ext) else $error("extension on full interface");
    a_fef: assert property (p_fef) else $error("far end fault with negotiation");
    a_irq: assert property (p_irq) else $error("interrupt on an input pin");
    a_pd: assert property (p_pd) else $error("power down without input pin");
    a_turn: assert property (p_turn) else $error("read turnaround too short");
endmodule // phyev_core_sva

bind phyev_core phyev_core_sva #(.ERR_LIMIT(ERR_LIMIT), .PHY_ADDR(PHY_ADDR)) phyev_core_sva_i (
    .mclk(mclk), .srst(srst), .mii_strap(mii_strap), .mdc(mdc), .mdio_i(mdio_i), .link(link), .evt(evt),
    .tx_en(tx_en), .crs_dv(crs_dv), .powerdown_or_irq_pin_i(powerdown_or_irq_pin_i), .mdio_o(mdio_o),
    .mdio_oe(mdio_oe), .powerdown_or_irq_pin_o(powerdown_or_irq_pin_o),
    .powerdown_or_irq_pin_oe(powerdown_or_irq_pin_oe), .powerdown_req(powerdown_req),
    .mii_select(mii_select), .elastic_extend(elastic_extend), .oob_signal_active(oob_signal_active),
    .far_end_fault_active(far_end_fault_active), .autoneg_allowed(autoneg_allowed),
    .scramble_allowed(scramble_allowed));

// File: bench/phyev_mac.sv
// phyev_mac: management master standing in for the MAC side
module phyev_mac
    import phyev_pkg::*;
(
    // clock
    input wire logic mclk,
    // management pins
    output logic mdc,
    output logic mdio_i,
    input wire logic mdio_o,
    input wire logic mdio_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    logic md = 1'b1;
    logic md_oe = 1'b1;
    // released line is pulled up, so an undriven bus reads ones
    assign mdio_i = mdio_oe ? mdio_o : (md_oe ? md : 1'b1);
    initial mdc = 1'b0;

    // one mdc period of 4 mclk; data changes while mdc is low
    task automatic bit_cyc(input logic b, input logic drv, output logic s);
        @(negedge mclk);
        mdc = 1'b0;
        md = b;
        md_oe = drv;
        repeat (2) @(negedge mclk);
        mdc = 1'b1;
        s = mdio_i;
        @(negedge mclk);
    endtask

    // short preamble, then header, turnaround and 16 data bits msb first
    task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
                         output logic [15:0] rd);
        logic [33:0] f;
        logic s;
        logic rdn;
        f = {4'hD, op, PHY_ADDR_DEFAULT, ra, 2'h2, wd};
        rdn = (op == OP_READ);
        for (int i = 33; i >= 0; i--) begin
            bit_cyc(f[i], !(rdn && i < 18), s);
            if (i < 16) rd[i] = s;
        end
        bit_cyc(1'b1, 1'b1, s);
    endtask
endmodule // phyev_mac

// File: bench/phyev_core_tb.sv
// phyev_core_tb: self-checking bench for phyev_core
module phyev_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import phyev_pkg::*;

    typedef struct packed {
        logic [6:0] ev;
        logic [2:0] n;
        logic [15:0] en;
        logic [15:0] st;
        logic pin;
    } phyev_row_t;

    logic mclk, srst, mii_strap, mdc, mdio_i, mdio_o, mdio_oe, tx_en, crs_dv, pin_o, pin_oe, pd_drv;
    logic powerdown_req, mii_select, elastic_extend, oob, fef, an_ok, scr_ok;
    wire logic pin_i;
    phyev_link_t link;
    phyev_evt_t evt;
    logic [15:0] rdv;
    int n_fail = 0;
    int num_checks = 0;
    // event, pulses, enable word, status read, pin level (low = pending)
    phyev_row_t rows [11] = '{
        '{7'h40, 3'd1, 16'h00C0, 16'h0040, 1'b0}, '{7'h20, 3'd1, 16'h00A0, 16'h0020, 1'b0},
        '{7'h10, 3'd1, 16'h0090, 16'h0010, 1'b0}, '{7'h08, 3'd1, 16'h0088, 16'h0008, 1'b0},
        '{7'h04, 3'd1, 16'h0084, 16'h0004, 1'b0}, '{7'h02, 3'd1, 16'h0082, 16'h0002, 1'b0},
        '{7'h01, 3'd4, 16'h0081, 16'h0001, 1'b0}, '{7'h01, 3'd3, 16'h0081, 16'h0000, 1'b1},
        '{7'h40, 3'd1, 16'h0040, 16'h0040, 1'b1}, '{7'h40, 3'd1, 16'h00BF, 16'h0040, 1'b1},
        '{7'h40, 3'd1, 16'h01C0, 16'h0040, 1'b1}};

    assign pin_i = pin_oe ? pin_o : pd_drv;

    phyev_core #(.ERR_LIMIT(4)) phyev_core_i (.mclk(mclk), .srst(srst), .mii_strap(mii_strap), .mdc(mdc),
        .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .link(link), .evt(evt), .tx_en(tx_en),
        .crs_dv(crs_dv), .powerdown_or_irq_pin_i(pin_i), .powerdown_or_irq_pin_o(pin_o),
        .powerdown_or_irq_pin_oe(pin_oe), .powerdown_req(powerdown_req), .mii_select(mii_select),
        .elastic_extend(elastic_extend), .oob_signal_active(oob), .far_end_fault_active(fef),
        .autoneg_allowed(an_ok), .scramble_allowed(scr_ok));
    phyev_mac phyev_mac_i (.mclk(mclk), .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        phyev_mac_i.frame(OP_WRITE, a, d, rdv);
        repeat (2) @(negedge mclk);
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
        phyev_mac_i.frame(OP_READ, a, 16'h0000, rdv);
        check(rdv, exp);
    endtask
    task automatic pulse(input logic [6:0] e);
        @(negedge mclk);
        evt = phyev_evt_t'(e);
        @(negedge mclk);
        evt = '0;
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // a hang is cut short here and reported as a mismatch
    initial begin
        repeat (60000) @(posedge mclk);
        n_fail++;
        finish_test();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        srst = 1'b1;
        mii_strap = 1'b1;
        link = '0;
        evt = '0;
        tx_en = 1'b0;
        crs_dv = 1'b0;
        pd_drv = 1'b1;
        repeat (3) @(negedge mclk);
        srst = 1'b0;
        rd_chk(REG_TEST_CTRL, 16'h1200);
        rd_chk(REG_IRQ_EN, 16'h0100);
        rd_chk(REG_STATUS, 16'h0000);
        rd_chk(5'h13, 16'h0000);
        check(16'(powerdown_req), 16'h0001);
        $display("test reset done");
        foreach (rows[k]) begin
            wr(REG_IRQ_EN, rows[k].en);
            repeat (rows[k].n) pulse(rows[k].ev);
            repeat (3) @(negedge mclk);
            check(16'(pin_o), 16'(rows[k].pin));
            rd_chk(REG_STATUS, rows[k].st);
            rd_chk(REG_STATUS, 16'h0000);
            check(16'(pin_o), 16'h0001);
        end
        $display("test events done");
        wr(REG_TEST_CTRL, 16'hFFFF);
        rd_chk(REG_TEST_CTRL, 16'h37E7);
        check({mii_select, elastic_extend}, 16'h0002);
        wr(REG_TEST_CTRL, 16'h0026);
        check({mii_select, elastic_extend, oob, fef}, 16'h0007);
        tx_en = 1'b1;
        repeat (2) @(negedge mclk);
        check(16'(oob), 16'h0000);
        tx_en = 1'b0;
        crs_dv = 1'b1;
        link = phyev_link_t'(7'h08);
        repeat (2) @(negedge mclk);
        check({oob, fef, an_ok}, 16'h0001);
        crs_dv = 1'b0;
        $display("test control done");
        link = phyev_link_t'(7'h77);
        rd_chk(REG_STATUS, 16'h0780);
        check({an_ok, scr_ok}, 16'h0000);
        link = phyev_link_t'(7'h33);
        wr(REG_STATUS, 16'hFFFF);
        rd_chk(REG_STATUS, 16'h0300);
        wr(REG_IRQ_EN, 16'hFFFF);
        rd_chk(REG_IRQ_EN, 16'h01FF);
        $display("test status done");
        // a flag pending at a mid-run reset must be gone, and the strap taken again
        pulse(7'h40);
        srst = 1'b1;
        mii_strap = 1'b0;
        repeat (3) @(negedge mclk);
        srst = 1'b0;
        rd_chk(REG_STATUS, 16'h0300);
        rd_chk(REG_TEST_CTRL, 16'h1000);
        rd_chk(REG_IRQ_EN, 16'h0100);
        $display("test mid reset done");
        finish_test();
    end
endmodule // phyev_core_tb
